// file: rtl/pps_top.sv
`timescale 1ns/10ps
`default_nettype none

module pps_top #(
    // Pin presence for the package variant; a cleared bit is absent
    parameter logic [31:0] IO_PIN_IMPL = 32'hFFFFFFFF,
    parameter logic [11:0] IN_ONLY_IMPL = 12'hFFF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_wr_word,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] config_word_two,
    input wire logic [43:0] remap_pin_in,
    input wire logic [43:0] remap_pin_analog,
    input wire logic [37:0] periph_out,
    output logic [63:0] periph_in,
    output logic [31:0] remap_io_pin_out,
    output logic [31:0] remap_io_pin_sel,
    output logic map_write_lock,
    output logic cfg_mismatch_rst
);

    pps_map_if map ();

    logic [5:0] in_sel_r [pps_pkg::NUM_IN_FUNC];
    logic [5:0] out_sel_r [pps_pkg::NUM_IO_PIN];
    logic [43:0] pin_impl;
    logic in_reg;
    logic out_reg;
    logic osc_wr;
    logic map_wr;
    logic commit;
    logic one_way;
    logic [5:0] in_f;
    logic [4:0] out_p;
    logic [4:0] rd_p;
    logic [5:0] rd_f;
    pps_pkg::pps_key_t key_r;
    logic lock_r;
    logic [15:0] rdata_nxt;
    logic [63:0] pin_in_nxt;
    logic [31:0] pin_out_nxt;
    logic [31:0] pin_sel_nxt;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Input selection names a present, digital remappable pin
    function automatic logic pin_usable(input logic [5:0] s,
                                        input logic [43:0] impl,
                                        input logic [43:0] analog);
        pin_usable = 1'b0;
        if (s <= pps_pkg::MAX_PIN_CODE)
            pin_usable = impl[s] && !analog[s];
    endfunction

    // Output code names a real peripheral output, not null or unused
    function automatic logic code_live(input logic [5:0] c);
        code_live = (c != pps_pkg::OUT_CODE_NULL) &&
                    (c <= pps_pkg::OUT_CODE_MOD);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Write decode

    // Input-only pins sit above the input/output pins
    assign pin_impl = {IN_ONLY_IMPL, IO_PIN_IMPL};
    assign in_reg = (reg_addr < pps_pkg::IDX_OUT_BASE);
    assign out_reg = (reg_addr >= pps_pkg::IDX_OUT_BASE) &&
                     (reg_addr < pps_pkg::IDX_OSC);
    assign osc_wr = reg_wr && (reg_addr == pps_pkg::IDX_OSC);
    assign map_wr = reg_wr && (in_reg || out_reg);
    // A locked write is accepted on the port but dropped here
    assign commit = map_wr && !lock_r;
    assign one_way = config_word_two[pps_pkg::ONE_WAY_BIT];
    assign in_f = {reg_addr[4:0], 1'b0};
    assign out_p = {reg_addr[3:0], 1'b0};

    ////////////////////////////////////////////////////////////////////
    // Input selection registers, two fields per register

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < pps_pkg::NUM_IN_FUNC; i++)
                in_sel_r[i] <= pps_pkg::IN_SEL_RST;
        end
        else if (commit && in_reg)
        begin
            in_sel_r[in_f] <= pps_pkg::lo_field(reg_wdata);
            if (reg_wr_word)
                in_sel_r[in_f + 6'h01] <= pps_pkg::hi_field(reg_wdata);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output selection registers, one field per pin

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < pps_pkg::NUM_IO_PIN; i++)
                out_sel_r[i] <= pps_pkg::OUT_SEL_RST;
        end
        else if (commit && out_reg)
        begin
            // Absent pins keep no field, so their writes vanish
            if (IO_PIN_IMPL[out_p])
                out_sel_r[out_p] <= pps_pkg::lo_field(reg_wdata);
            if (reg_wr_word && IO_PIN_IMPL[out_p + 5'h01])
                out_sel_r[out_p + 5'h01] <= pps_pkg::hi_field(reg_wdata);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Unlock key sequence

    // Only register-port writes advance or abort; idle cycles do not
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            key_r <= pps_pkg::KEY_IDLE;
        else if (reg_wr)
        begin
            unique case (key_r)
                pps_pkg::KEY_IDLE:
                begin
                    if (osc_wr && reg_wdata[7:0] == pps_pkg::KEY_FIRST)
                        key_r <= pps_pkg::KEY_ONE;
                end
                pps_pkg::KEY_ONE:
                begin
                    if (osc_wr && reg_wdata[7:0] == pps_pkg::KEY_SECOND)
                        key_r <= pps_pkg::KEY_TWO;
                    else
                        key_r <= pps_pkg::KEY_IDLE;
                end
                pps_pkg::KEY_TWO:
                    key_r <= pps_pkg::KEY_IDLE;
                default:
                    key_r <= pps_pkg::KEY_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mapping write lock

    // Holds until the next keyed write; nothing relocks by itself
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            lock_r <= 1'b0;
        else if (osc_wr && key_r == pps_pkg::KEY_TWO)
        begin
            // One-way mode freezes a set lock until device reset
            if (!(one_way && lock_r))
                lock_r <= reg_wdata[pps_pkg::LOCK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read back

    assign rd_f = {reg_addr[4:0], 1'b0};
    assign rd_p = {reg_addr[3:0], 1'b0};

    // Stored fields are visible whatever the lock says
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (in_reg)
        begin
            rdata_nxt[pps_pkg::LO_LSB +: pps_pkg::FW] = in_sel_r[rd_f];
            rdata_nxt[pps_pkg::HI_LSB +: pps_pkg::FW] =
                in_sel_r[rd_f + 6'h01];
        end
        else if (out_reg)
        begin
            if (IO_PIN_IMPL[rd_p])
                rdata_nxt[pps_pkg::LO_LSB +: pps_pkg::FW] = out_sel_r[rd_p];
            if (IO_PIN_IMPL[rd_p + 5'h01])
                rdata_nxt[pps_pkg::HI_LSB +: pps_pkg::FW] =
                    out_sel_r[rd_p + 5'h01];
        end
        else if (reg_addr == pps_pkg::IDX_OSC)
            rdata_nxt[pps_pkg::LOCK_BIT] = lock_r;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= rdata_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Input routing: each peripheral input takes one pin at most

    // A single field per input means two pins can never fight for it;
    // one pin may still appear in many fields.
    always_comb
    begin
        for (int f = 0; f < pps_pkg::NUM_IN_FUNC; f++)
        begin
            if (pin_usable(in_sel_r[f], pin_impl, remap_pin_analog))
                pin_in_nxt[f] = remap_pin_in[in_sel_r[f]];
            else
                pin_in_nxt[f] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            periph_in <= 64'h0000000000000000;
        else
            periph_in <= pin_in_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Output routing: each pin takes one peripheral output at most

    // Only data and a select flag leave here; direction, drive and the
    // peripheral enables stay with their own owners.
    always_comb
    begin
        for (int p = 0; p < pps_pkg::NUM_IO_PIN; p++)
        begin
            if (code_live(out_sel_r[p]) && IO_PIN_IMPL[p])
            begin
                pin_out_nxt[p] = periph_out[out_sel_r[p]];
                pin_sel_nxt[p] = 1'b1;
            end
            else
            begin
                pin_out_nxt[p] = 1'b0;
                pin_sel_nxt[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            remap_io_pin_out <= 32'h00000000;
            remap_io_pin_sel <= 32'h00000000;
        end
        else
        begin
            remap_io_pin_out <= pin_out_nxt;
            remap_io_pin_sel <= pin_sel_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shadow monitor hook-up

    assign map.wr_commit = commit;
    assign map.wr_word = reg_wr_word;
    assign map.wr_idx = reg_addr;
    assign map.wr_data = reg_wdata;

    always_comb
    begin
        for (int i = 0; i < pps_pkg::NUM_IN_FUNC; i++)
            map.in_flat[i*pps_pkg::FW +: pps_pkg::FW] = in_sel_r[i];
        for (int i = 0; i < pps_pkg::NUM_IO_PIN; i++)
            map.out_flat[i*pps_pkg::FW +: pps_pkg::FW] = out_sel_r[i];
    end

    pps_shadow #(
        .IO_PIN_IMPL(IO_PIN_IMPL)
    ) u_shadow (
        .clk(clk),
        .resetn(resetn),
        .map(map.monitor)
    );

    // Status outputs straight from flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            map_write_lock <= 1'b0;
            cfg_mismatch_rst <= 1'b0;
        end
        else
        begin
            map_write_lock <= lock_r;
            cfg_mismatch_rst <= map.mismatch;
        end
    end

endmodule // pps_top

`default_nettype wire

// file: rtl/pps_pkg.sv

package pps_pkg;

    // Sizes of the fabric
    localparam int FW = 6;
    localparam int NUM_IN_REG = 32;
    localparam int NUM_IN_FUNC = 64;
    localparam int NUM_OUT_REG = 16;
    localparam int NUM_IO_PIN = 32;
    localparam int NUM_IN_ONLY = 12;
    localparam int NUM_PIN = 44;
    localparam int NUM_OUT_FUNC = 38;

    // Reset values of the fields
    localparam logic [5:0] IN_SEL_RST = 6'h3F;
    localparam logic [5:0] OUT_SEL_RST = 6'h00;

    // Selection codes
    localparam logic [5:0] MAX_PIN_CODE = 6'h2B;
    localparam logic [5:0] OUT_CODE_NULL = 6'h00;
    localparam logic [5:0] OUT_CODE_MOD = 6'h25;

    // Register indices
    localparam logic [5:0] IDX_IN_BASE = 6'h00;
    localparam logic [5:0] IDX_OUT_BASE = 6'h20;
    localparam logic [5:0] IDX_OSC = 6'h30;

    // Field positions
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 8;
    localparam int LOCK_BIT = 6;
    localparam int ONE_WAY_BIT = 4;

    // Unlock keys written to the low byte of oscillator control
    localparam logic [7:0] KEY_FIRST = 8'h46;
    localparam logic [7:0] KEY_SECOND = 8'h57;

    // Key sequence states
    typedef enum logic [2:0] {
        KEY_IDLE = 3'h1,
        KEY_ONE = 3'h2,
        KEY_TWO = 3'h4
    } pps_key_t;

    // Low field of a write word
    function automatic logic [5:0] lo_field(input logic [15:0] d);
        lo_field = d[LO_LSB +: FW];
    endfunction

    // High field of a write word
    function automatic logic [5:0] hi_field(input logic [15:0] d);
        hi_field = d[HI_LSB +: FW];
    endfunction

endpackage

// file: rtl/pps_map_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries committed writes and the live map to the shadow monitor
interface pps_map_if;
    logic wr_commit;
    logic wr_word;
    logic [5:0] wr_idx;
    logic [15:0] wr_data;
    logic [pps_pkg::NUM_IN_FUNC*pps_pkg::FW-1:0] in_flat;
    logic [pps_pkg::NUM_IO_PIN*pps_pkg::FW-1:0] out_flat;
    logic mismatch;

    modport primary (
        output wr_commit,
        output wr_word,
        output wr_idx,
        output wr_data,
        output in_flat,
        output out_flat,
        input mismatch
    );

    modport monitor (
        input wr_commit,
        input wr_word,
        input wr_idx,
        input wr_data,
        input in_flat,
        input out_flat,
        output mismatch
    );
endinterface

`default_nettype wire

// file: rtl/pps_shadow.sv
`timescale 1ns/10ps
`default_nettype none

module pps_shadow #(
    parameter logic [31:0] IO_PIN_IMPL = 32'hFFFFFFFF
) (
    input wire logic clk,
    input wire logic resetn,
    pps_map_if.monitor map
);

    logic [5:0] in_sh_r [pps_pkg::NUM_IN_FUNC];
    logic [5:0] out_sh_r [pps_pkg::NUM_IO_PIN];
    logic [pps_pkg::NUM_IN_FUNC*pps_pkg::FW-1:0] in_sh_flat;
    logic [pps_pkg::NUM_IO_PIN*pps_pkg::FW-1:0] out_sh_flat;
    logic in_reg;
    logic [5:0] in_f;
    logic [4:0] out_p;

    ////////////////////////////////////////////////////////////////////
    // Independent write path, so a disturbed cell is not copied over
    assign in_reg = (map.wr_idx < pps_pkg::IDX_OUT_BASE);
    assign in_f = {map.wr_idx[4:0], 1'b0};
    assign out_p = {map.wr_idx[3:0], 1'b0};

    // Shadow of the input fields
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < pps_pkg::NUM_IN_FUNC; i++)
                in_sh_r[i] <= pps_pkg::IN_SEL_RST;
        end
        else if (map.wr_commit && in_reg)
        begin
            in_sh_r[in_f] <= pps_pkg::lo_field(map.wr_data);
            if (map.wr_word)
                in_sh_r[in_f + 6'h01] <= pps_pkg::hi_field(map.wr_data);
        end
    end

    // Shadow of the output fields
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < pps_pkg::NUM_IO_PIN; i++)
                out_sh_r[i] <= pps_pkg::OUT_SEL_RST;
        end
        else if (map.wr_commit && !in_reg)
        begin
            if (IO_PIN_IMPL[out_p])
                out_sh_r[out_p] <= pps_pkg::lo_field(map.wr_data);
            if (map.wr_word && IO_PIN_IMPL[out_p + 5'h01])
                out_sh_r[out_p + 5'h01] <= pps_pkg::hi_field(map.wr_data);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flatten shadows for a single wide compare
    always_comb
    begin
        for (int i = 0; i < pps_pkg::NUM_IN_FUNC; i++)
            in_sh_flat[i*pps_pkg::FW +: pps_pkg::FW] = in_sh_r[i];
        for (int i = 0; i < pps_pkg::NUM_IO_PIN; i++)
            out_sh_flat[i*pps_pkg::FW +: pps_pkg::FW] = out_sh_r[i];
    end

    // Mismatch stays up until the device reset it requests arrives
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            map.mismatch <= 1'b0;
        else if ((in_sh_flat != map.in_flat) || (out_sh_flat != map.out_flat))
            map.mismatch <= 1'b1;
    end

endmodule // pps_shadow

`default_nettype wire

// file: dv/pps_props.sv
`timescale 1ns/10ps
`default_nettype none

module pps_props #(
    parameter logic [31:0] IO_PIN_IMPL = 32'hFFFFFFFF,
    parameter logic [11:0] IN_ONLY_IMPL = 12'hFFF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_wr_word,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] config_word_two,
    input wire logic [43:0] remap_pin_in,
    input wire logic [43:0] remap_pin_analog,
    input wire logic [37:0] periph_out,
    input wire logic [63:0] periph_in,
    input wire logic [31:0] remap_io_pin_out,
    input wire logic [31:0] remap_io_pin_sel,
    input wire logic map_write_lock,
    input wire logic cfg_mismatch_rst
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] key_r;
    logic lock_r;
    logic osc_wr;
    assign osc_wr = reg_wr && reg_addr == pps_pkg::IDX_OSC;

    // Own key tracker; only writes move it, so idle gaps are harmless
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            key_r <= 2'h0;
            lock_r <= 1'b0;
        end
        else if (reg_wr)
        begin
            key_r <= !osc_wr ? 2'h0
                : (key_r == 2'h0 && reg_wdata[7:0] == 8'h46) ? 2'h1
                : (key_r == 2'h1 && reg_wdata[7:0] == 8'h57) ? 2'h2 : 2'h0;
            if (osc_wr && key_r == 2'h2 && !(config_word_two[4] && lock_r))
                lock_r <= reg_wdata[6];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_lock_rst;
        $rose(resetn) |-> !map_write_lock && periph_in == 64'h0
            && remap_io_pin_sel == 32'h0;
    endproperty
    a_lock_rst: assert property (p_lock_rst)
        else $error("state not clear after reset");

    property p_lock_key;
        osc_wr && key_r == 2'h2 |-> ##2 map_write_lock == lock_r;
    endproperty
    a_lock_key: assert property (p_lock_key)
        else $error("lock did not follow the key write");

    property p_lock_hold;
        !(osc_wr && key_r == 2'h2) |-> ##2 $stable(map_write_lock);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock moved without a full key sequence");

    property p_one_way;
        config_word_two[4] && lock_r |-> ##2 map_write_lock;
    endproperty
    a_one_way: assert property (p_one_way)
        else $error("one-way lock was cleared");

    property p_mismatch;
        reg_wr |=> !cfg_mismatch_rst [*3];
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("mismatch reset after a legal write");

    property p_out_off;
        (remap_io_pin_out & ~remap_io_pin_sel) == 32'h0;
    endproperty
    a_out_off: assert property (p_out_off)
        else $error("pin driven without a live code");

    property p_sel_impl;
        (remap_io_pin_sel & ~IO_PIN_IMPL) == 32'h0;
    endproperty
    a_sel_impl: assert property (p_sel_impl)
        else $error("absent pin has a live output");

    property p_rd_pad;
        $past(reg_addr) < pps_pkg::IDX_OSC |-> (reg_rdata & 16'hC0C0) == 16'h0;
    endproperty
    a_rd_pad: assert property (p_rd_pad)
        else $error("unused mapping bits read nonzero");

    property p_osc_rd;
        $past(reg_addr) == pps_pkg::IDX_OSC |-> reg_rdata[6] == map_write_lock;
    endproperty
    a_osc_rd: assert property (p_osc_rd)
        else $error("lock readback differs from lock");

    // Main scenarios the bench is expected to reach
    c_key: cover property (osc_wr && key_r == 2'h2);
    c_locked_wr: cover property (reg_wr && lock_r && reg_addr < 6'h30);
    c_one_way: cover property (osc_wr && key_r == 2'h2 && config_word_two[4]
        && lock_r);
endmodule // pps_props

bind pps_top pps_props #(
    .IO_PIN_IMPL(IO_PIN_IMPL),
    .IN_ONLY_IMPL(IN_ONLY_IMPL)
) u_props (
    .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_wr_word(reg_wr_word),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .config_word_two(config_word_two), .remap_pin_in(remap_pin_in),
    .remap_pin_analog(remap_pin_analog), .periph_out(periph_out),
    .periph_in(periph_in), .remap_io_pin_out(remap_io_pin_out),
    .remap_io_pin_sel(remap_io_pin_sel), .map_write_lock(map_write_lock),
    .cfg_mismatch_rst(cfg_mismatch_rst)
);

`default_nettype wire

// file: dv/pps_far_model.sv
`timescale 1ns/10ps
`default_nettype none

module pps_far_model (
    input wire logic [15:0] lvl,
    output logic [43:0] pin_lvl,
    output logic [43:0] pin_ana,
    output logic [37:0] fn_lvl
);
    // Pins and peripherals scrambled from one seed; lanes 16 apart share a seed bit,
    // some equal and some inverted, so a wrong mux select may still give the right level
    assign pin_lvl = {lvl[11:0], ~lvl, lvl ^ 16'h5A5A};
    // Only upper pins go analog, so most routes still carry live data
    assign pin_ana = {lvl & {lvl[3:0], lvl[15:4]}, 28'h0};
    assign fn_lvl = {lvl[5:0], lvl ^ 16'h3C3C, ~lvl};
endmodule // pps_far_model

`default_nettype wire

// file: dv/test_remappable_pin_select_lock.sv
`timescale 1ns/10ps
`default_nettype none

module test_remappable_pin_select_lock;
    // Smaller variant: pins 5, 15, 31, 32, 39 and 41 absent
    localparam logic [31:0] IO_IMPL = 32'h7FFF7FDF;
    localparam logic [11:0] IN_IMPL = 12'hD7E;
    logic clk, resetn, reg_wr, reg_wr_word, map_write_lock, mism;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, config_word_two, lf;
    logic [43:0] pin_lvl, pin_ana;
    logic [37:0] fn_lvl;
    logic [63:0] periph_in;
    logic [31:0] pin_out, pin_sel;
    logic [5:0] in_m [64];
    logic [5:0] out_m [32];
    logic lk_m;
    logic [1:0] key_m;
    int err_count, n_tests;

    pps_far_model far (.lvl(lf), .pin_lvl(pin_lvl), .pin_ana(pin_ana),
        .fn_lvl(fn_lvl));
    pps_top #(.IO_PIN_IMPL(IO_IMPL), .IN_ONLY_IMPL(IN_IMPL)) uut (
        .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_wr_word(reg_wr_word),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .config_word_two(config_word_two), .remap_pin_in(pin_lvl),
        .remap_pin_analog(pin_ana), .periph_out(fn_lvl), .periph_in(periph_in),
        .remap_io_pin_out(pin_out), .remap_io_pin_sel(pin_sel),
        .map_write_lock(map_write_lock), .cfg_mismatch_rst(mism));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected {pin select, pin data, peripheral inputs} from the mirror
    function automatic logic [127:0] exp_route();
        logic [43:0] impl;
        logic [5:0] s;
        exp_route = 128'h0;
        impl = {IN_IMPL, IO_IMPL};
        for (int f = 0; f < 64; f++)
        begin
            s = in_m[f];
            if (s <= pps_pkg::MAX_PIN_CODE && impl[s] && !pin_ana[s])
                exp_route[f] = pin_lvl[s];
        end
        for (int p = 0; p < 32; p++)
        begin
            s = out_m[p];
            if (s != 6'h00 && s <= pps_pkg::OUT_CODE_MOD && IO_IMPL[p])
            begin
                exp_route[96 + p] = 1'b1;
                exp_route[64 + p] = fn_lvl[s];
            end
        end
    endfunction

    function automatic logic [15:0] exp_rd(input logic [5:0] a);
        int i;
        i = 2 * int'(a[4:0]);
        exp_rd = 16'h0000;
        if (a < 6'h20)
            exp_rd = {2'h0, in_m[i + 1], 2'h0, in_m[i]};
        else if (a < 6'h30)
            exp_rd = {2'h0, out_m[i + 1], 2'h0, out_m[i]};
        else if (a == 6'h30)
            exp_rd = {9'h000, lk_m, 6'h00};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Drives at the falling edge and returns; the rising edge between two
    // calls takes the write, so back-to-back calls are legal
    task automatic wr(input logic [5:0] a, input logic [15:0] d,
        input logic w);
        int i;
        logic osc;
        i = 2 * int'(a[4:0]);
        osc = a == pps_pkg::IDX_OSC;
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_word = w;
        if (!lk_m && a < 6'h20)
            in_m[i] = d[5:0];
        if (!lk_m && a < 6'h20 && w)
            in_m[i + 1] = d[13:8];
        if (!lk_m && a[5:4] == 2'h2 && IO_IMPL[i])
            out_m[i] = d[5:0];
        if (!lk_m && a[5:4] == 2'h2 && w && IO_IMPL[i + 1])
            out_m[i + 1] = d[13:8];
        if (osc && key_m == 2'h2 && !(config_word_two[4] && lk_m))
            lk_m = d[6];
        key_m = !osc ? 2'h0 : (key_m == 2'h0 && d[7:0] == 8'h46) ? 2'h1
            : (key_m == 2'h1 && d[7:0] == 8'h57) ? 2'h2 : 2'h0;
    endtask

    task automatic idle();
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic key_seq(input logic set);
        wr(pps_pkg::IDX_OSC, {8'h00, pps_pkg::KEY_FIRST}, 1'b0);
        wr(pps_pkg::IDX_OSC, {8'h00, pps_pkg::KEY_SECOND}, 1'b0);
        wr(pps_pkg::IDX_OSC, {9'h000, set, 6'h00}, 1'b0);
    endtask

    // Oscillator control is kept out so random data never forms a key
    task automatic rand_wr(input int n);
        logic [5:0] a;
        for (int j = 0; j < n; j++)
        begin
            lf = lfsr(lf);
            a = (lf[5:0] == pps_pkg::IDX_OSC) ? 6'h31 : lf[5:0];
            wr(a, lfsr(lf) ^ {lf[7:0], lf[15:8]}, lf[6]);
        end
    endtask

    // Reads every index, then routes random pin and peripheral levels
    task automatic chk_all();
        logic [15:0] m;
        idle();
        for (int a = 0; a < 64; a++)
        begin
            reg_addr = 6'(a);
            m = (a == 48) ? 16'h0040 : 16'hFFFF;
            @(negedge clk);
            chk(128'(reg_rdata & m), 128'(exp_rd(6'(a)) & m));
        end
        chk(128'(map_write_lock), 128'(lk_m));
        // Legal writes keep shadow and live map equal, so no reset request
        chk(128'(mism), 128'h0);
        for (int r = 0; r < 8; r++)
        begin
            lf = lfsr(lf);
            @(negedge clk);
            chk({pin_sel, pin_out, periph_in}, exp_route());
        end
    endtask

    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        reg_wr = 1'b0;
        lk_m = 1'b0;
        key_m = 2'h0;
        foreach (in_m[i])
            in_m[i] = pps_pkg::IN_SEL_RST;
        foreach (out_m[i])
            out_m[i] = pps_pkg::OUT_SEL_RST;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // A hang counts as a mismatch and still reaches the verdict
    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        complete_run();
    end

    initial
    begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_wr_word = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        lf = 16'h22CB;
        err_count = 0;
        n_tests = 0;
        config_word_two = 16'h0010;
        do_reset();
        chk_all();
        wr(6'h20, 16'h2625, 1'b1);
        wr(6'h22, 16'h3F25, 1'b1);
        wr(6'h27, 16'h2525, 1'b1);
        wr(6'h00, 16'h2C2B, 1'b1);
        wr(6'h01, 16'h2B2B, 1'b1);
        wr(6'h02, 16'h2720, 1'b1);
        wr(6'h03, 16'h1111, 1'b0);
        rand_wr(40);
        chk_all();
        key_seq(1'b1);
        rand_wr(20);
        chk_all();
        key_seq(1'b0);
        rand_wr(10);
        chk_all();
        do_reset();
        config_word_two = 16'h0000;
        chk_all();
        rand_wr(20);
        key_seq(1'b1);
        wr(6'h30, 16'h0046, 1'b0);
        wr(6'h3F, 16'h0000, 1'b1);
        wr(6'h30, 16'h0057, 1'b0);
        wr(6'h30, 16'h0000, 1'b0);
        wr(6'h30, 16'h0046, 1'b0);
        wr(6'h30, 16'h0046, 1'b0);
        wr(6'h30, 16'h0057, 1'b0);
        wr(6'h30, 16'h0000, 1'b0);
        rand_wr(10);
        chk_all();
        wr(6'h30, 16'h0046, 1'b0);
        idle();
        wr(6'h30, 16'h0057, 1'b0);
        idle();
        wr(6'h30, 16'h0000, 1'b0);
        rand_wr(30);
        wr(6'h2F, 16'h0000, 1'b1);
        chk_all();
        key_seq(1'b1);
        chk_all();
        complete_run();
    end
endmodule // test_remappable_pin_select_lock

`default_nettype wire
